/* hw/annp_pkg.sv */
// Function
// [RULE1] Partner next page capable bit set when received word shows next page.
// [RULE2] Local next page capable bit always reads one.
// [RULE3] Page received flag sets when a new partner word is stored.
// [RULE4] A read of the expansion status register clears page received.
// [RULE5] Page received latches high until cleared.
// [RULE6] Partner autoneg capable is zero until valid pulse bursts arrive, then one.
// [RULE7] Outgoing more pages flag copies the register bit.
// [RULE8] Next pages go out only when register bit set and partner capable.
// [RULE9] Reserved bit of next page transmit register reads zero.
// [RULE10] Software writes default values into reserved bits on every write.
// [RULE11] Outgoing page type flag comes from the register bit.
// [RULE12] Outgoing comply ack flag comes from the register bit.
// [RULE13] Toggle inverts with each transmitted next page word.
// [RULE14] First next page toggle is inverse of base word bit 11.
// [RULE15] Eleven-bit code field goes into the outgoing code positions.
// [RULE16] Writes to toggle and reserved bits are ignored.
package annp_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] ANNP_EXP_IDX = 8'h06;
	localparam logic [7:0] ANNP_NPTX_IDX = 8'h07;
	localparam logic [7:0] ANNP_IRQ_STAT_IDX = 8'h20;
	localparam logic [7:0] ANNP_IRQ_MASK_IDX = 8'h21;
	localparam int ANNP_NP_BIT = 15;
	localparam int ANNP_RSV_BIT = 14;
	localparam int ANNP_MP_BIT = 13;
	localparam int ANNP_COMPLY_ACK_FLAG_BIT = 12;
	localparam int ANNP_TOG_BIT = 11;
	localparam int ANNP_CODE_W = 11;
	localparam int ANNP_BASE_TOG_BIT = 11;
	localparam int ANNP_LPNP_BIT = 3;
	localparam int ANNP_LNP_BIT = 2;
	localparam int ANNP_PR_BIT = 1;
	localparam int ANNP_LPAN_BIT = 0;
	localparam logic [15:0] ANNP_NPTX_RST = 16'h2001;
	localparam logic [2:0] ANNP_IRQ_RST = 3'h0;

	typedef struct packed {
		logic more_pages_flag;
		logic page_type_flag;
		logic comply_ack_flag;
		logic toggle;
		logic [10:0] code;
	} annp_page_type;

	typedef struct packed {
		logic [15:0] nptx;
		logic toggle;
		logic first_np;
		logic lp_np_able;
		logic page_rx;
		logic lp_an_able;
		logic [2:0] irq_stat;
		logic [2:0] irq_mask;
		logic ack;
		logic [31:0] dat;
		logic irq;
		annp_page_type page;
		logic np_enable;
	} annp_state_type;
endpackage

/* hw/annp_regs.sv */
`timescale 1ns/100ps
module annp_regs (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq_o,
	input wire logic lcw_stored_i,
	input wire logic [15:0] lcw_rx_i,
	input wire logic flp_valid_i,
	input wire logic [15:0] base_word_i,
	input wire logic base_sent_i,
	input wire logic np_sent_i,
	input wire logic an_restart_i,
	output annp_pkg::annp_page_type np_page_o,
	output logic np_enable_o
);
	import annp_pkg::*;

	// ****************************************
	// Bus decode
	// ****************************************
	annp_state_type s_r;
	annp_state_type s_nxt;
	logic req;
	logic [7:0] idx;
	logic [15:0] exp_word;
	logic [2:0] ev;

	assign req = wb_cyc_i && wb_stb_i && !s_r.ack;
	assign idx = wb_adr_i[9:2];
	assign wb_dat_o = s_r.dat;
	assign wb_ack_o = s_r.ack;
	assign irq_o = s_r.irq;
	assign np_page_o = s_r.page;
	assign np_enable_o = s_r.np_enable;

	always_comb begin
		exp_word = 16'h0000;
		exp_word[ANNP_LPNP_BIT] = s_r.lp_np_able;
		exp_word[ANNP_LNP_BIT] = 1'b1; // [RULE2]
		exp_word[ANNP_PR_BIT] = s_r.page_rx;
		exp_word[ANNP_LPAN_BIT] = s_r.lp_an_able;
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_nxt = s_r;
		s_nxt.ack = req;
		ev = {lcw_stored_i, flp_valid_i && !s_r.lp_an_able, np_sent_i};
		if (lcw_stored_i && lcw_rx_i[ANNP_NP_BIT]) begin
			s_nxt.lp_np_able = 1'b1; // [RULE1]
		end
		if (flp_valid_i) begin
			s_nxt.lp_an_able = 1'b1; // [RULE6]
		end
		if (req && !wb_we_i) begin
			s_nxt.dat = 32'h0000_0000;
			unique case (idx)
				ANNP_EXP_IDX: begin
					s_nxt.dat[15:0] = exp_word;
					s_nxt.page_rx = 1'b0; // [RULE4]
				end
				ANNP_NPTX_IDX: begin
					s_nxt.dat[15:0] = s_r.nptx;
					s_nxt.dat[ANNP_RSV_BIT] = 1'b0; // [RULE9]
					s_nxt.dat[ANNP_TOG_BIT] = s_r.toggle;
				end
				ANNP_IRQ_STAT_IDX: begin
					s_nxt.dat[2:0] = s_r.irq_stat;
					s_nxt.irq_stat = 3'h0;
				end
				ANNP_IRQ_MASK_IDX: begin
					s_nxt.dat[2:0] = s_r.irq_mask;
				end
				default: begin
					s_nxt.dat = 32'h0000_0000;
				end
			endcase
		end
		if (req && wb_we_i) begin
			if (idx == ANNP_NPTX_IDX) begin
				if (wb_sel_i[1]) begin
					s_nxt.nptx[ANNP_NP_BIT] = wb_dat_i[ANNP_NP_BIT];
					s_nxt.nptx[ANNP_MP_BIT] = wb_dat_i[ANNP_MP_BIT];
					s_nxt.nptx[ANNP_COMPLY_ACK_FLAG_BIT] = wb_dat_i[ANNP_COMPLY_ACK_FLAG_BIT];
					s_nxt.nptx[10:8] = wb_dat_i[10:8]; // Toggle and reserved kept [RULE16]
				end
				if (wb_sel_i[0]) begin
					s_nxt.nptx[7:0] = wb_dat_i[7:0];
				end
			end
			if (idx == ANNP_IRQ_MASK_IDX && wb_sel_i[0]) begin
				s_nxt.irq_mask = wb_dat_i[2:0];
			end
		end
		// Set beats read clear, so an arrival during the read is not lost
		if (lcw_stored_i) begin
			s_nxt.page_rx = 1'b1; // [RULE3] [RULE5]
		end
		s_nxt.irq_stat = s_nxt.irq_stat | ev;
		if (an_restart_i) begin
			s_nxt.first_np = 1'b1;
		end
		if (base_sent_i) begin
			s_nxt.toggle = ~base_word_i[ANNP_BASE_TOG_BIT]; // [RULE14]
			s_nxt.first_np = 1'b0;
		end else if (np_sent_i) begin
			s_nxt.toggle = ~s_r.toggle; // [RULE13]
		end
		s_nxt.page.more_pages_flag = s_nxt.nptx[ANNP_NP_BIT]; // [RULE7]
		s_nxt.page.page_type_flag = s_nxt.nptx[ANNP_MP_BIT]; // [RULE11]
		s_nxt.page.comply_ack_flag = s_nxt.nptx[ANNP_COMPLY_ACK_FLAG_BIT]; // [RULE12]
		s_nxt.page.toggle = s_nxt.toggle;
		s_nxt.page.code = s_nxt.nptx[ANNP_CODE_W-1:0]; // [RULE15]
		s_nxt.np_enable = s_nxt.nptx[ANNP_NP_BIT] && s_nxt.lp_np_able; // [RULE8]
		s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
		if (rst_i) begin
			s_nxt = '0;
			s_nxt.nptx = ANNP_NPTX_RST;
			s_nxt.first_np = 1'b1;
			s_nxt.irq_stat = ANNP_IRQ_RST;
			s_nxt.irq_mask = ANNP_IRQ_RST;
			s_nxt.page.page_type_flag = ANNP_NPTX_RST[ANNP_MP_BIT];
			s_nxt.page.code = ANNP_NPTX_RST[ANNP_CODE_W-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		s_r <= s_nxt;
	end

	// ****************************************
	// Check helpers
	// ****************************************
	// Decoded strobes keep the properties short; they hold no state
	logic rd_exp;
	logic rd_nptx;
	logic rd_stat;
	logic wr_nptx;
	assign rd_exp = req && !wb_we_i && idx == ANNP_EXP_IDX;
	assign rd_nptx = req && !wb_we_i && idx == ANNP_NPTX_IDX;
	assign rd_stat = req && !wb_we_i && idx == ANNP_IRQ_STAT_IDX;
	assign wr_nptx = req && wb_we_i && idx == ANNP_NPTX_IDX;

	// ****************************************
	// Bus handshake
	// ****************************************
	a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		req |=> wb_ack_o)
		else $error("request not acknowledged");

	a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("acknowledge longer than one cycle");

	a_ack_cause: assert property (@(posedge clk_i) disable iff (rst_i)
		!req |=> !wb_ack_o)
		else $error("acknowledge without request");

	a_dat_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!(req && !wb_we_i) |=> $stable(wb_dat_o))
		else $error("read data moved without a read");

	a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && !rd_exp && !rd_nptx && !rd_stat && idx != ANNP_IRQ_MASK_IDX)
		|=> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");

	a_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i) |=> wb_dat_o[31:16] == 16'h0000)
		else $error("upper read half not zero");

	// ****************************************
	// Expansion status
	// ****************************************
	a_pr_set: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE3]
		lcw_stored_i |=> s_r.page_rx)
		else $error("page received not set");

	a_pr_clear: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE4]
		(rd_exp && !lcw_stored_i) |=> !s_r.page_rx)
		else $error("page received not cleared by read");

	a_pr_latch: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
		(s_r.page_rx && !rd_exp) |=> s_r.page_rx)
		else $error("page received dropped");

	a_pr_cause: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE3]
		(!s_r.page_rx && !lcw_stored_i) |=> !s_r.page_rx)
		else $error("page received set with no word");

	a_pr_read: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE4]
		rd_exp |=> wb_dat_o[ANNP_PR_BIT] == $past(s_r.page_rx))
		else $error("page received read wrong");

	a_lpnp_set: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
		(lcw_stored_i && lcw_rx_i[ANNP_NP_BIT]) |=> s_r.lp_np_able)
		else $error("partner next page not set");

	a_lpnp_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
		s_r.lp_np_able |=> s_r.lp_np_able)
		else $error("partner next page dropped");

	a_lpnp_cause: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
		(!s_r.lp_np_able && !(lcw_stored_i && lcw_rx_i[ANNP_NP_BIT])) |=> !s_r.lp_np_able)
		else $error("partner next page set with no cause");

	a_lpnp_read: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
		rd_exp |=> wb_dat_o[ANNP_LPNP_BIT] == $past(s_r.lp_np_able))
		else $error("partner next page read wrong");

	a_lnp_one: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2]
		rd_exp |=> wb_dat_o[ANNP_LNP_BIT])
		else $error("local next page capable read zero");

	a_exp_rsv: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_exp |=> wb_dat_o[15:4] == 12'h000)
		else $error("expansion upper bits not zero");

	a_lpan_set: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE6]
		flp_valid_i |=> s_r.lp_an_able)
		else $error("partner autoneg not set");

	a_lpan_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE6]
		s_r.lp_an_able |=> s_r.lp_an_able)
		else $error("partner autoneg lost");

	a_lpan_cause: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE6]
		(!s_r.lp_an_able && !flp_valid_i) |=> !s_r.lp_an_able)
		else $error("partner autoneg set with no bursts");

	a_lpan_read: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE6]
		rd_exp |=> wb_dat_o[ANNP_LPAN_BIT] == $past(s_r.lp_an_able))
		else $error("partner autoneg read wrong");

	// ****************************************
	// Next page transmit
	// ****************************************
	a_tog_flip: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE13]
		(np_sent_i && !base_sent_i) |=> s_r.page.toggle != $past(s_r.page.toggle))
		else $error("toggle did not invert");

	a_tog_init: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE14]
		base_sent_i |=> s_r.page.toggle == !$past(base_word_i[ANNP_BASE_TOG_BIT]))
		else $error("toggle init wrong");

	a_tog_ro: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE16]
		(!base_sent_i && !np_sent_i) |=> $stable(s_r.toggle))
		else $error("toggle moved with no sent word");

	a_tog_read: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE13]
		rd_nptx |=> wb_dat_o[ANNP_TOG_BIT] == $past(s_r.toggle))
		else $error("toggle read wrong");

	a_tog_out: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE13]
		s_r.page.toggle == s_r.toggle)
		else $error("outgoing toggle differs");

	a_np_gate: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
		s_r.np_enable |-> (s_r.nptx[ANNP_NP_BIT] && s_r.lp_np_able))
		else $error("next page enabled wrongly");

	a_np_en_set: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
		(s_r.nptx[ANNP_NP_BIT] && s_r.lp_np_able) |-> s_r.np_enable)
		else $error("next page not enabled");

	a_rsv_read: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE9]
		rd_nptx |=> !wb_dat_o[ANNP_RSV_BIT])
		else $error("reserved bit read one");

	a_ro_write: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE16]
		!s_r.nptx[ANNP_RSV_BIT])
		else $error("reserved bit changed");

	a_nptx_tog0: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE16]
		!s_r.nptx[ANNP_TOG_BIT])
		else $error("toggle position written");

	a_nptx_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!wr_nptx |=> $stable(s_r.nptx))
		else $error("transmit register moved with no write");

	a_np_write: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
		(wr_nptx && wb_sel_i[1]) |=> s_r.nptx[ANNP_NP_BIT] == $past(wb_dat_i[ANNP_NP_BIT]))
		else $error("more pages bit not written");

	a_code_write: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE15]
		(wr_nptx && wb_sel_i[0]) |=> s_r.nptx[7:0] == $past(wb_dat_i[7:0]))
		else $error("code low byte not written");

	a_page_copy: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
		s_r.page.more_pages_flag == s_r.nptx[ANNP_NP_BIT])
		else $error("outgoing more pages mismatch");

	a_mp_out: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE11]
		s_r.page.page_type_flag == s_r.nptx[ANNP_MP_BIT])
		else $error("outgoing page type mismatch");

	a_comply_ack_flag_out: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE12]
		s_r.page.comply_ack_flag == s_r.nptx[ANNP_COMPLY_ACK_FLAG_BIT])
		else $error("outgoing comply ack mismatch");

	a_code_out: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE15]
		s_r.page.code == s_r.nptx[ANNP_CODE_W-1:0])
		else $error("outgoing code mismatch");

	// ****************************************
	// Interrupt and restart
	// ****************************************
	a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_o == |(s_r.irq_stat & s_r.irq_mask))
		else $error("interrupt level wrong");

	a_irq_pr: assert property (@(posedge clk_i) disable iff (rst_i)
		lcw_stored_i |=> s_r.irq_stat[2])
		else $error("stored word status not set");

	a_irq_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_r.irq_stat[2] && !rd_stat) |=> s_r.irq_stat[2])
		else $error("stored word status dropped");

	a_irq_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		(rd_stat && !lcw_stored_i && !flp_valid_i && !np_sent_i) |=> s_r.irq_stat == 3'h0)
		else $error("status not cleared by read");

	a_first_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		base_sent_i |=> !s_r.first_np)
		else $error("first page marker not cleared");

	a_first_set: assert property (@(posedge clk_i) disable iff (rst_i)
		(an_restart_i && !base_sent_i) |=> s_r.first_np)
		else $error("first page marker not set");
endmodule

/* sim/annp_lp_model.sv */
`timescale 1ns/100ps
module annp_lp_model (
	input wire logic clk_i,
	output logic stored_o,
	output logic [15:0] word_o,
	output logic flp_o,
	output logic base_sent_o,
	output logic np_sent_o
);
	initial begin
		{stored_o, flp_o, base_sent_o, np_sent_o} = 4'h0;
		word_o = 16'h0000;
	end
	// Word flips after use so a design reading it late sees garbage
	task automatic ev(input int k, input logic [15:0] w);
		word_o <= w;
		stored_o <= (k == 0);
		flp_o <= (k == 1);
		base_sent_o <= (k == 2);
		np_sent_o <= (k == 3);
		@(posedge clk_i);
		{stored_o, flp_o, base_sent_o, np_sent_o} <= 4'h0;
		word_o <= ~w;
		@(posedge clk_i);
	endtask
endmodule

/* sim/test_autoneg_next_page_status_regs.sv */
`timescale 1ns/100ps
module test_autoneg_next_page_status_regs;
	import annp_pkg::*;
	logic clk_i, rst_i, cyc, stb, we, stored, flp, bsent, nsent, irq, np_en, t, ack;
	logic [9:0] adr;
	logic [31:0] wdat, rdat, q;
	logic [15:0] word, v;
	annp_page_type pg;
	int n_errors, checks;
	annp_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .irq_o(irq), .lcw_stored_i(stored), .lcw_rx_i(word),
		.flp_valid_i(flp), .base_word_i(word), .base_sent_i(bsent), .np_sent_i(nsent),
		.an_restart_i(1'b0), .np_page_o(pg), .np_enable_o(np_en));
	annp_lp_model lp (.clk_i(clk_i), .stored_o(stored), .word_o(word), .flp_o(flp),
		.base_sent_o(bsent), .np_sent_o(nsent));
	// ****************
	// Helpers
	// ****************
	function automatic logic [31:0] rdv(logic [15:0] r, logic tg);
		return {16'h0000, r[15], 1'b0, r[13:12], tg, r[10:0]};
	endfunction
	function automatic logic [31:0] npw(logic [15:0] r, logic tg);
		return {17'h00000, r[15], r[13:12], tg, r[10:0]};
	endfunction
	task automatic summarize;
		if (n_errors == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'h0};
		wdat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat;
		if (n >= 20) begin
			n_errors++;
			summarize();
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	initial begin
		{cyc, stb, we, rst_i} = 4'h1;
		adr = 10'h000;
		wdat = 32'h0;
		n_errors = 0;
		checks = 0;
		void'($urandom(27973));
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk({17'h0, pg}, npw(16'h2001, 1'b0));
		bus(1'b0, 8'h07, 32'h0);
		chk(q, rdv(16'h2001, 1'b0));
		bus(1'b0, 8'h06, 32'h0);
		chk(q, 32'h4);
		bus(1'b0, 8'h30, 32'h0);
		chk(q, 32'h0);
		bus(1'b1, 8'h21, 32'h4);
		for (int i = 0; i < 5; i++) begin
			v = (i == 0) ? 16'hBFFF : 16'($urandom) & 16'hBFFF;
			if (i == 4) v = 16'h9555;
			bus(1'b1, 8'h07, {16'h0, v});
			bus(1'b0, 8'h07, 32'h0);
			chk(q, rdv(v, 1'b0));
			chk({17'h0, pg}, npw(v, 1'b0));
			chk({31'h0, np_en}, 32'h0);
		end
		lp.ev(1, 16'h0000);
		lp.ev(0, 16'h8000);
		chk({31'h0, irq}, 32'h1);
		bus(1'b0, 8'h06, 32'h0);
		chk(q, 32'hF);
		bus(1'b0, 8'h06, 32'h0);
		chk(q, 32'hD);
		chk({31'h0, np_en}, 32'h1);
		bus(1'b0, 8'h20, 32'h0);
		chk(q, 32'h6);
		chk({31'h0, irq}, 32'h0);
		t = 1'b1;
		lp.ev(2, 16'h0000);
		for (int i = 0; i < 3; i++) begin
			chk({17'h0, pg}, npw(16'h9555, t));
			lp.ev(3, 16'h0000);
			t = ~t;
		end
		bus(1'b0, 8'h07, 32'h0);
		chk(q, rdv(16'h9555, t));
		chk({31'h0, irq}, 32'h0);
		bus(1'b0, 8'h20, 32'h0);
		chk(q, 32'h1);
		summarize();
	end
endmodule
